// ===== design/bspm_top.sv
// Boot strap pin function mux: routes multifunction pins by strap and hibernate.
// Assumes pins are resolved outside from the enables; output enables are active low, input enables active high.
`include "bspm_defines.svh"
module bspm_top #(
  parameter int HIB_CYC = `BSPM_HIB_ENTRY_CYC, // Host low time to hibernate
  parameter int PULSE_CYC = `BSPM_PULSE_CYC    // Motion report pulse length
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic BOOT_STRAP_SELECT_I,
  input wire logic HOST_PORT_STRAP_I,
  input wire logic SPI_THREE_WIRE_I,
  input wire logic [1:0] PIN1_CFG_I,
  input wire logic [1:0] PIN2_CFG_I,
  input wire logic PIN2_TRIGGER_SEL_I,
  input wire logic CFG_LOAD_I,
  input wire logic INTERRUPT_ONE_I,
  input wire logic INTERRUPT_TWO_I,
  input wire logic BOOT_DONE_I,
  input wire logic MOTION_DETECT_I,
  input wire logic HIBERNATE_REQ_I,
  input wire logic WAKE_REQ_I,
  input wire logic PIN1_I,
  input wire logic PIN2_I,
  input wire logic CS_N_I,
  input wire logic TARGET_ADDRESS_LSB_PIN_I,
  input wire logic SPI_MISO_I,
  input wire logic SERIAL_DATA_OUT_I,
  input wire logic SERIAL_DATA_OE_I,
  output logic PIN1_O,
  output logic PIN1_OE_N_O,
  output logic PIN2_O,
  output logic PIN2_OE_N_O,
  output logic MISO_O,
  output logic MISO_OE_N_O,
  output logic SDA_O,
  output logic SDA_OE_N_O,
  output logic SCL_INPUT_EN_O,
  output logic CS_INPUT_EN_O,
  output logic MODE_MOTION_O,
  output logic SPI_MODE_O,
  output logic SPI_THREE_WIRE_O,
  output logic ADDRESS_LSB_O,
  output logic HIBERNATE_O,
  output logic EXTERNAL_MEASURE_TRIGGER_O,
  output logic THRESHOLD_LEVEL_O,
  output logic WAKE_EVENT_O
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] sync_boot; // Boot strap sampler
  logic [2:0] sync_port; // Port strap sampler
  logic [2:0] sync_pin1; // Shared motion line sampler
  logic [2:0] sync_pin2; // Trigger input sampler
  logic [2:0] sync_cs; // Chip select sampler
  logic [2:0] sync_sa0; // Address pin sampler
  logic boot_level; // Filtered strap level
  logic port_level; // Filtered port strap level
  logic line_level; // Filtered shared line level
  logic trig_level; // Filtered trigger level
  logic cs_level; // Filtered chip select level
  logic sa0_level; // Filtered address level

  // Three stages; a change counts when stages two and three agree
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sync_boot <= 3'h0;
      sync_port <= 3'h0;
      sync_pin1 <= 3'h7;
      sync_pin2 <= 3'h0;
      sync_cs <= 3'h7;
      sync_sa0 <= 3'h0;
    end else begin
      sync_boot <= {sync_boot[1:0], BOOT_STRAP_SELECT_I};
      sync_port <= {sync_port[1:0], HOST_PORT_STRAP_I};
      sync_pin1 <= {sync_pin1[1:0], PIN1_I};
      sync_pin2 <= {sync_pin2[1:0], PIN2_I};
      sync_cs <= {sync_cs[1:0], CS_N_I};
      sync_sa0 <= {sync_sa0[1:0], TARGET_ADDRESS_LSB_PIN_I};
    end
  end

  // Filtered levels; stage one is never read here
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      boot_level <= 1'b0;
      port_level <= 1'b0;
      line_level <= 1'b1;
      trig_level <= 1'b0;
      cs_level <= 1'b1;
      sa0_level <= 1'b0;
    end else begin
      if (sync_boot[1] == sync_boot[2]) boot_level <= sync_boot[2];
      if (sync_port[1] == sync_port[2]) port_level <= sync_port[2];
      if (sync_pin1[1] == sync_pin1[2]) line_level <= sync_pin1[2];
      if (sync_pin2[1] == sync_pin2[2]) trig_level <= sync_pin2[2];
      if (sync_cs[1] == sync_cs[2]) cs_level <= sync_cs[2];
      if (sync_sa0[1] == sync_sa0[2]) sa0_level <= sync_sa0[2];
    end
  end

  // ----------------------------------------
  // Strap capture after reset release
  // ----------------------------------------
  bspm_pkg::bspm_strap_t strap_state; // Capture sequencer
  logic [7:0] settle; // Wait for synchronisers to fill
  logic motion_mode; // Latched boot strap
  logic spi_mode; // Latched port strap

  // Strap caught once, after the samplers have settled
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      strap_state <= bspm_pkg::BSPM_WAIT;
      settle <= 8'h00;
      motion_mode <= 1'b0;
      spi_mode <= 1'b0;
    end else begin
      case (strap_state)
        bspm_pkg::BSPM_WAIT: begin
          settle <= settle + 8'h01;
          if (settle == `BSPM_RELEASE_LEN) strap_state <= bspm_pkg::BSPM_SAMPLE;
        end
        bspm_pkg::BSPM_SAMPLE: begin
          motion_mode <= boot_level;
          spi_mode <= port_level;
          strap_state <= bspm_pkg::BSPM_HELD;
        end
        bspm_pkg::BSPM_HELD: strap_state <= bspm_pkg::BSPM_HELD;
        default: strap_state <= bspm_pkg::BSPM_WAIT;
      endcase
    end
  end

  logic strap_ready; // Pins stay released until straps are known
  assign strap_ready = (strap_state == bspm_pkg::BSPM_HELD);

  // ----------------------------------------
  // Hibernate control
  // ----------------------------------------
  logic hibernate; // Device asleep
  logic pulse_active; // Line pulled low by device
  logic [31:0] low_count; // Host low time on shared line
  logic cs_prev; // Last chip select level for wake edge

  // Motion mode: long host low enters sleep, line high leaves it
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hibernate <= 1'b0;
      low_count <= 32'h0;
      cs_prev <= 1'b1;
    end else begin
      cs_prev <= cs_level;
      if (motion_mode && strap_ready) begin
        // Own pulse is not counted as host low
        if (!line_level && !pulse_active) begin
          if (low_count < 32'(HIB_CYC)) low_count <= low_count + 32'h1;
        end else begin
          low_count <= 32'h0;
        end
        if (low_count == 32'(HIB_CYC)) hibernate <= 1'b1;
        else if (line_level && hibernate) hibernate <= 1'b0;
      end else if (strap_ready) begin
        low_count <= 32'h0;
        if (HIBERNATE_REQ_I) hibernate <= 1'b1;
        else if (hibernate && (WAKE_REQ_I || (cs_prev && !cs_level))) hibernate <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Motion report pulse
  // ----------------------------------------
  logic [31:0] pulse_count; // Pulse length counter

  // Fixed-length low pulse; detections during a pulse are merged
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pulse_active <= 1'b0;
      pulse_count <= 32'h0;
    end else if (pulse_active) begin
      if (pulse_count == 32'(PULSE_CYC - 1)) pulse_active <= 1'b0;
      pulse_count <= pulse_count + 32'h1;
    end else if (MOTION_DETECT_I && motion_mode && strap_ready && !hibernate && line_level) begin
      pulse_active <= 1'b1;
      pulse_count <= 32'h0;
    end
  end

  // ----------------------------------------
  // Interrupt pin configuration
  // ----------------------------------------
  logic [1:0] pin1_cfg; // Pin one driver type
  logic [1:0] pin2_cfg; // Pin two driver type

  // Back to push-pull on reset and while in hibernate
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pin1_cfg <= `BSPM_PIN_PUSH_PULL;
      pin2_cfg <= `BSPM_PIN_PUSH_PULL;
    end else if (hibernate) begin
      pin1_cfg <= `BSPM_PIN_PUSH_PULL;
      pin2_cfg <= `BSPM_PIN_PUSH_PULL;
    end else if (CFG_LOAD_I) begin
      pin1_cfg <= PIN1_CFG_I;
      pin2_cfg <= PIN2_CFG_I;
    end
  end

  // Drive level and enable for one pin by its driver type
  function automatic logic [1:0] drive(input logic [1:0] cfg, input logic val);
    logic [1:0] r; // {level, enable_n}
    r = {1'b0, 1'b1};
    case (cfg)
      `BSPM_PIN_PUSH_PULL: r = {val, 1'b0};
      `BSPM_PIN_OPEN_DRAIN: r = {1'b0, val};
      `BSPM_PIN_OPEN_SOURCE: r = {1'b1, !val};
      default: r = {1'b0, 1'b1};
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // Pin routing, selected by latched straps and hibernate state
  // ----------------------------------------
  logic [1:0] p1; // Pin one drive
  logic [1:0] p2; // Pin two drive
  logic active; // Straps known and awake

  always_comb begin
    active = strap_ready && !hibernate;
    p1 = {1'b0, 1'b1};
    p2 = {1'b0, 1'b1};
    if (active && !motion_mode) begin
      p1 = drive(pin1_cfg, INTERRUPT_ONE_I);
      if (!PIN2_TRIGGER_SEL_I) p2 = drive(pin2_cfg, INTERRUPT_TWO_I);
    end else if (active) begin
      p1 = {1'b0, !pulse_active};
      p2 = {1'b0, BOOT_DONE_I};
    end
  end

  assign PIN1_O = p1[1];
  assign PIN1_OE_N_O = p1[0];
  assign PIN2_O = p2[1];
  assign PIN2_OE_N_O = p2[0];
  // Serial pins released in hibernate
  assign MISO_O = SPI_MISO_I;
  assign MISO_OE_N_O = !(active && spi_mode && !SPI_THREE_WIRE_I && SERIAL_DATA_OE_I);
  assign SDA_O = spi_mode ? SERIAL_DATA_OUT_I : 1'b0;
  assign SDA_OE_N_O = !(active && SERIAL_DATA_OE_I && (spi_mode ? SPI_THREE_WIRE_I : !SERIAL_DATA_OUT_I));
  assign SCL_INPUT_EN_O = active;
  // Hibernate input buffers follow the strap
  assign CS_INPUT_EN_O = !hibernate || !motion_mode;
  assign MODE_MOTION_O = motion_mode;
  assign SPI_MODE_O = spi_mode;
  assign SPI_THREE_WIRE_O = spi_mode && SPI_THREE_WIRE_I;
  assign ADDRESS_LSB_O = !spi_mode && sa0_level;
  assign HIBERNATE_O = hibernate;
  assign EXTERNAL_MEASURE_TRIGGER_O = active && !motion_mode && PIN2_TRIGGER_SEL_I && trig_level;
  assign THRESHOLD_LEVEL_O = motion_mode && line_level;
  assign WAKE_EVENT_O = hibernate && !motion_mode && cs_prev && !cs_level;
endmodule // bspm_top

// ===== common/bspm_defines.svh
// Constants for the boot strap pin function mux.
// Assumes a 50 MHz reference clock; included by bare name.
`ifndef BSPM_DEFINES_SVH
`define BSPM_DEFINES_SVH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define BSPM_CLK_MHZ 50
`define BSPM_HIB_ENTRY_US 10
`define BSPM_HIB_ENTRY_CYC ((`BSPM_HIB_ENTRY_US * `BSPM_CLK_MHZ) + 1)
`define BSPM_PULSE_US 10
`define BSPM_PULSE_CYC (`BSPM_PULSE_US * `BSPM_CLK_MHZ)
// ----------------------------------------
// Interrupt pin configuration codes and strap settle count
// ----------------------------------------
`define BSPM_PIN_PUSH_PULL 2'h0
`define BSPM_PIN_OPEN_DRAIN 2'h1
`define BSPM_PIN_OPEN_SOURCE 2'h2
`define BSPM_PIN_INPUT 2'h3
`define BSPM_RELEASE_LEN 8'h03
`endif

// ===== common/bspm_pkg.sv
// Types for the boot strap pin function mux.
// Assumes nothing beyond the defines header.
package bspm_pkg;
  // ----------------------------------------
  // Strap capture states, Gray coded
  // ----------------------------------------
  typedef enum logic [1:0] {
    BSPM_WAIT = 2'h0,
    BSPM_SAMPLE = 2'h1,
    BSPM_HELD = 2'h3
  } bspm_strap_t;
endpackage

// ===== bench/bspm_sva.sv
// Checker for the boot strap pin mux pin controls.
// Assumes it is bound into bspm_top; one clock, async low reset.
module bspm_sva #(
  parameter int PULSE_CYC = 8
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic MOTION_DETECT_I,
  input wire logic PIN1_OE_N_O,
  input wire logic PIN2_O,
  input wire logic PIN2_OE_N_O,
  input wire logic MISO_OE_N_O,
  input wire logic SDA_OE_N_O,
  input wire logic CS_INPUT_EN_O,
  input wire logic MODE_MOTION_O,
  input wire logic SPI_MODE_O,
  input wire logic HIBERNATE_O,
  input wire logic THRESHOLD_LEVEL_O,
  input wire logic WAKE_EVENT_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Low cycles of the running motion report
  int low_cnt;
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= (MODE_MOTION_O && !PIN1_OE_N_O) ? low_cnt + 1 : 0;
    end
  end
  chk_strap_kept: assert property (MODE_MOTION_O |=> MODE_MOTION_O)
    else $error("boot strap latch lost");
  chk_port_kept: assert property (SPI_MODE_O |=> SPI_MODE_O)
    else $error("port strap latch lost");
  chk_serial_hiz: assert property (HIBERNATE_O |-> MISO_OE_N_O && SDA_OE_N_O)
    else $error("serial pin driven in hibernate");
  chk_hib_pins: assert property (HIBERNATE_O |-> PIN1_OE_N_O && CS_INPUT_EN_O == !MODE_MOTION_O)
    else $error("pin state wrong in hibernate");
  chk_pulse_len: assert property ($rose(PIN1_OE_N_O) && MODE_MOTION_O |-> low_cnt == PULSE_CYC)
    else $error("motion report length wrong");
  chk_pulse_start: assert property (MODE_MOTION_O && !HIBERNATE_O && PIN1_OE_N_O && THRESHOLD_LEVEL_O
    && MOTION_DETECT_I |=> !PIN1_OE_N_O)
    else $error("motion report not started");
  chk_drain_only: assert property (MODE_MOTION_O && !PIN2_OE_N_O |-> !PIN2_O)
    else $error("boot done pin driven high");
  chk_wake_pulse: assert property (WAKE_EVENT_O |-> !MODE_MOTION_O ##1 !WAKE_EVENT_O)
    else $error("wake event wrong");
  cov_report: cover property ($rose(PIN1_OE_N_O) && MODE_MOTION_O);
  cov_hib: cover property ($rose(HIBERNATE_O));
  cov_wake: cover property (WAKE_EVENT_O);
endmodule // bspm_sva
bind bspm_top bspm_sva #(.PULSE_CYC(PULSE_CYC)) u_sva (.*);

// ===== bench/bspm_host.sv
// Host end of the shared motion line with its board pull-up.
// Assumes the pin enable is active low.
module bspm_host (
  input wire logic pin_i,
  input wire logic pin_oe_n_i,
  input wire logic hold_low_i,
  output logic line_o
);
  // Pull-up unless host or device sinks the line
  assign line_o = hold_low_i ? 1'h0 : (pin_oe_n_i ? 1'h1 : pin_i);
endmodule // bspm_host

// ===== bench/bspm_top_tb.sv
// Bench for the boot strap pin mux: default boot, then motion boot.
// Assumes bspm_top with short counts and the host model on pin one.
`include "bspm_defines.svh"
module bspm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PC = 8; // Short pulse and hibernate counts
  logic REF_CLK_I, RST_N_I, BOOT_STRAP_SELECT_I, HOST_PORT_STRAP_I, SPI_THREE_WIRE_I;
  logic [1:0] PIN1_CFG_I, PIN2_CFG_I;
  logic PIN2_TRIGGER_SEL_I, CFG_LOAD_I, INTERRUPT_ONE_I, INTERRUPT_TWO_I, BOOT_DONE_I;
  logic MOTION_DETECT_I, HIBERNATE_REQ_I, WAKE_REQ_I, PIN1_I, PIN2_I, CS_N_I;
  logic TARGET_ADDRESS_LSB_PIN_I, SPI_MISO_I, SERIAL_DATA_OUT_I, SERIAL_DATA_OE_I;
  logic PIN1_O, PIN1_OE_N_O, PIN2_O, PIN2_OE_N_O, MISO_O, MISO_OE_N_O, SDA_O, SDA_OE_N_O;
  logic SCL_INPUT_EN_O, CS_INPUT_EN_O, MODE_MOTION_O, SPI_MODE_O, SPI_THREE_WIRE_O;
  logic ADDRESS_LSB_O, HIBERNATE_O, EXTERNAL_MEASURE_TRIGGER_O, THRESHOLD_LEVEL_O, WAKE_EVENT_O;
  logic hold_low; // Host sinks the motion line
  int n_errors, check_count, n_wake;
  bspm_top #(.HIB_CYC(PC), .PULSE_CYC(PC)) dut (.*);
  bspm_host host (.pin_i(PIN1_O), .pin_oe_n_i(PIN1_OE_N_O), .hold_low_i(hold_low), .line_o(PIN1_I));
  // Pin two pulled up when nobody drives it
  assign PIN2_I = PIN2_OE_N_O ? 1'h1 : PIN2_O;
  initial begin
    REF_CLK_I = 1'h0;
    forever #10 REF_CLK_I = ~REF_CLK_I;
  end
  always @(posedge REF_CLK_I) if (WAKE_EVENT_O === 1'h1) n_wake++;
  task automatic step(input int n);
    repeat (n) @(posedge REF_CLK_I);
    @(negedge REF_CLK_I);
  endtask
  task automatic chk(input string nm, input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic rst(input logic bs, input logic hs);
    @(posedge REF_CLK_I);
    RST_N_I <= 1'h0;
    BOOT_STRAP_SELECT_I <= bs;
    HOST_PORT_STRAP_I <= hs;
    repeat (12) @(posedge REF_CLK_I);
    RST_N_I <= 1'h1;
    step(12);
  endtask
  // Report pulses; second request mid-pulse must not stretch it
  task automatic motion;
    repeat (2) begin
      @(posedge REF_CLK_I);
      MOTION_DETECT_I <= 1'h1;
      @(posedge REF_CLK_I);
      MOTION_DETECT_I <= 1'h0;
    end
  endtask
  // Load a driver type for pin one, then let it settle
  task automatic load_cfg(input logic [1:0] cfg);
    @(posedge REF_CLK_I);
    PIN1_CFG_I <= cfg;
    CFG_LOAD_I <= 1'h1;
    @(posedge REF_CLK_I);
    CFG_LOAD_I <= 1'h0;
    step(2);
  endtask
  task automatic end_sim;
    $display("Checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, far beyond the walk below
  initial begin
    #200000;
    n_errors++;
    end_sim;
  end
  initial begin
    {RST_N_I, BOOT_STRAP_SELECT_I, HOST_PORT_STRAP_I, SPI_THREE_WIRE_I, PIN1_CFG_I, PIN2_CFG_I} = '0;
    {PIN2_TRIGGER_SEL_I, CFG_LOAD_I, INTERRUPT_ONE_I, INTERRUPT_TWO_I, BOOT_DONE_I} = '0;
    {MOTION_DETECT_I, HIBERNATE_REQ_I, WAKE_REQ_I, TARGET_ADDRESS_LSB_PIN_I, hold_low} = '0;
    {SPI_MISO_I, SERIAL_DATA_OUT_I, SERIAL_DATA_OE_I} = '0;
    CS_N_I = 1'h1;
    rst(1'h0, 1'h1);
    chk("mode", MODE_MOTION_O, 1'h0);
    chk("spi", SPI_MODE_O, 1'h1);
    @(posedge REF_CLK_I);
    BOOT_STRAP_SELECT_I <= 1'h1;
    HOST_PORT_STRAP_I <= 1'h0;
    INTERRUPT_ONE_I <= 1'h1;
    INTERRUPT_TWO_I <= 1'h1;
    SPI_THREE_WIRE_I <= 1'h1;
    SPI_MISO_I <= 1'h1;
    SERIAL_DATA_OUT_I <= 1'h1;
    SERIAL_DATA_OE_I <= 1'h1;
    step(10);
    chk("mode kept", MODE_MOTION_O, 1'h0);
    chk("spi kept", SPI_MODE_O, 1'h1);
    chk("pin1 oe", PIN1_OE_N_O, 1'h0);
    chk("pin1", PIN1_O, 1'h1);
    chk("pin2", PIN2_O, 1'h1);
    chk("3wire", SPI_THREE_WIRE_O, 1'h1);
    chk("scl on", SCL_INPUT_EN_O, 1'h1);
    chk("miso 3w", MISO_OE_N_O, 1'h1);
    chk("sda drv", SDA_OE_N_O, 1'h0);
    chk("sda", SDA_O, 1'h1);
    chk("miso", MISO_O, 1'h1);
    @(posedge REF_CLK_I);
    PIN2_TRIGGER_SEL_I <= 1'h1;
    PIN1_CFG_I <= `BSPM_PIN_OPEN_DRAIN;
    CFG_LOAD_I <= 1'h1;
    SPI_THREE_WIRE_I <= 1'h0;
    @(posedge REF_CLK_I);
    CFG_LOAD_I <= 1'h0;
    step(8);
    chk("trig in", PIN2_OE_N_O, 1'h1);
    chk("od", PIN1_OE_N_O, 1'h1);
    chk("trig", EXTERNAL_MEASURE_TRIGGER_O, 1'h1);
    chk("4wire", SPI_THREE_WIRE_O, 1'h0);
    chk("miso 4w", MISO_OE_N_O, 1'h0);
    chk("sda in", SDA_OE_N_O, 1'h1);
    load_cfg(`BSPM_PIN_OPEN_SOURCE);
    chk("os", PIN1_O, 1'h1);
    chk("os oe", PIN1_OE_N_O, 1'h0);
    load_cfg(`BSPM_PIN_INPUT);
    chk("input", PIN1_OE_N_O, 1'h1);
    @(posedge REF_CLK_I);
    HIBERNATE_REQ_I <= 1'h1;
    step(8);
    chk("hib", HIBERNATE_O, 1'h1);
    chk("miso", MISO_OE_N_O, 1'h1);
    chk("sda", SDA_OE_N_O, 1'h1);
    chk("pin1 hiz", PIN1_OE_N_O, 1'h1);
    chk("cs in", CS_INPUT_EN_O, 1'h1);
    chk("scl off", SCL_INPUT_EN_O, 1'h0);
    @(posedge REF_CLK_I);
    HIBERNATE_REQ_I <= 1'h0;
    CS_N_I <= 1'h0;
    step(10);
    chk("woke", HIBERNATE_O, 1'h0);
    chk("wake", n_wake == 1, 1'h1);
    chk("pp", PIN1_OE_N_O, 1'h0);
    // Default-mode sleep left by the wake request, not by chip select
    @(posedge REF_CLK_I);
    HIBERNATE_REQ_I <= 1'h1;
    @(posedge REF_CLK_I);
    HIBERNATE_REQ_I <= 1'h0;
    step(2);
    chk("hib again", HIBERNATE_O, 1'h1);
    @(posedge REF_CLK_I);
    WAKE_REQ_I <= 1'h1;
    @(posedge REF_CLK_I);
    WAKE_REQ_I <= 1'h0;
    step(2);
    chk("wake req", HIBERNATE_O, 1'h0);
    rst(1'h1, 1'h0);
    chk("motion", MODE_MOTION_O, 1'h1);
    chk("i2c", SPI_MODE_O, 1'h0);
    chk("booting", PIN2_OE_N_O, 1'h0);
    chk("thr hi", THRESHOLD_LEVEL_O, 1'h1);
    @(posedge REF_CLK_I);
    BOOT_DONE_I <= 1'h1;
    TARGET_ADDRESS_LSB_PIN_I <= 1'h1;
    BOOT_STRAP_SELECT_I <= 1'h0;
    HOST_PORT_STRAP_I <= 1'h1;
    SERIAL_DATA_OUT_I <= 1'h0;
    step(8);
    chk("booted", PIN2_OE_N_O, 1'h1);
    chk("addr", ADDRESS_LSB_O, 1'h1);
    chk("motion kept", MODE_MOTION_O, 1'h1);
    chk("i2c kept", SPI_MODE_O, 1'h0);
    chk("i2c sda", SDA_OE_N_O, 1'h0);
    chk("i2c sda lo", SDA_O, 1'h0);
    motion();
    step(PC - 3);
    chk("report", PIN1_OE_N_O, 1'h0);
    step(1);
    chk("report end", PIN1_OE_N_O, 1'h1);
    step(6);
    hold_low <= 1'h1;
    step(6);
    chk("thr lo", THRESHOLD_LEVEL_O, 1'h0);
    hold_low <= 1'h0;
    step(8);
    chk("short low", HIBERNATE_O, 1'h0);
    hold_low <= 1'h1;
    step(20);
    chk("hib", HIBERNATE_O, 1'h1);
    chk("cs hiz", CS_INPUT_EN_O, 1'h0);
    motion();
    step(2);
    chk("refused", PIN1_OE_N_O, 1'h1);
    hold_low <= 1'h0;
    step(10);
    chk("awake", HIBERNATE_O, 1'h0);
    end_sim;
  end
endmodule // bspm_top_tb
